// ### core/cdus_params.svh
`ifndef CDUS_PARAMS_SVH
`define CDUS_PARAMS_SVH
`define CDUS_SRC_T0      3'h0
`define CDUS_SRC_T1      3'h1
`define CDUS_SRC_T2      3'h2
`define CDUS_SRC_T3      3'h3
`define CDUS_SRC_RISE    3'h4
`define CDUS_SRC_FALL    3'h5
`define CDUS_SRC_ANY     3'h6
`define CDUS_SRC_DEMAND  3'h7
`define CDUS_CTL_RESET   8'h73
`define CDUS_CTL_EN      7
`define CDUS_CTL_SRC_HI  6
`define CDUS_CTL_SRC_LO  4
`define CDUS_CTL_RSV     3
`define CDUS_CTL_RJST    2
`define CDUS_CTL_FS_HI   1
`define CDUS_CTL_FS_LO   0
`define CDUS_CTL_MASK    8'hf7
`define CDUS_BYTE_ZERO   8'h00
`define CDUS_WORD_ZERO   12'h000
`endif

// ### core/cdus_pkg.sv
`default_nettype none
package cdus_pkg;
	typedef struct packed {
		logic       enable;
		logic [2:0] source;
		logic       rightJust;
		logic [1:0] fullScale;
	} cdus_ctl_s;
	typedef struct packed {
		logic t0Ovf;
		logic t1Ovf;
		logic t2LowOvf;
		logic t2HighOvf;
		logic t2Split;
		logic t3LowOvf;
		logic t3HighOvf;
		logic t3Split;
	} cdus_tmr_s;
endpackage
`default_nettype wire

// ### core/cdus_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdus_params.svh"
module cdus_channel
(
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                clkEn,
	input  wire logic [7:0]          ctlWrData,
	input  wire logic                ctlWr,
	input  wire logic [7:0]          wrData,
	input  wire logic                highWr,
	input  wire logic                lowWr,
	input  wire logic [7:0]          evtVec,
	output logic [7:0]               ctlReg,
	output logic [7:0]               dataHighReg,
	output logic [7:0]               dataLowReg,
	output logic [11:0]              latchWord
);
	logic [7:0]  ctl_ff;
	logic [7:0]  high_ff;
	logic [7:0]  low_ff;
	logic [11:0] latch_ff;
	logic [2:0]  src;
	logic        demandHit;
	logic        evtHit;
	logic        doLoad;
	logic [7:0]  nxt_high;
	logic [7:0]  nxt_low;
	logic [11:0] nxt_word;

	function automatic logic [11:0] joinWord(input logic rj, input logic [7:0] h,
		input logic [7:0] l);
		joinWord = rj ? {h[3:0], l} : {h, l[7:4]};
	endfunction

	assign src       = ctl_ff[`CDUS_CTL_SRC_HI:`CDUS_CTL_SRC_LO];
	assign demandHit = (src == `CDUS_SRC_DEMAND) && highWr;
	assign evtHit    = (src != `CDUS_SRC_DEMAND) && evtVec[src];
	assign doLoad    = demandHit || evtHit;
	assign nxt_high  = highWr ? wrData : high_ff;
	assign nxt_low   = lowWr ? wrData : low_ff;
	assign nxt_word  = joinWord(ctl_ff[`CDUS_CTL_RJST], nxt_high, nxt_low);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctl_ff   <= `CDUS_CTL_RESET;
			high_ff  <= `CDUS_BYTE_ZERO;
			low_ff   <= `CDUS_BYTE_ZERO;
			latch_ff <= `CDUS_WORD_ZERO;
		end
		else if (clkEn)
		begin
			if (ctlWr)
				ctl_ff <= ctlWrData & `CDUS_CTL_MASK;
			high_ff <= nxt_high;
			low_ff  <= nxt_low;
			if (doLoad)
				latch_ff <= nxt_word;
		end
	end

	assign ctlReg      = ctl_ff;
	assign dataHighReg = high_ff;
	assign dataLowReg  = low_ff;
	assign latchWord   = latch_ff;

	AST_DEMAND_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && highWr && !ctlWr && src == `CDUS_SRC_DEMAND) |=>
		latch_ff == joinWord(ctl_ff[`CDUS_CTL_RJST], high_ff, low_ff))
		else $error("demand write did not load latch");
	AST_LOW_HELD: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && !doLoad) |=> $stable(latch_ff))
		else $error("latch changed without a load event");
	AST_EVT_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && evtHit && !highWr && !lowWr && !ctlWr) |=>
		latch_ff == joinWord(ctl_ff[`CDUS_CTL_RJST], high_ff, low_ff))
		else $error("event did not load latch");
	AST_HOLD_NO_EVT: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && src != `CDUS_SRC_DEMAND && !evtVec[src]) |=> $stable(latch_ff))
		else $error("held mode loaded without event");
	AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
		ctl_ff[`CDUS_CTL_RSV] == 1'b0)
		else $error("reserved control bit set");
endmodule
`default_nettype wire

// ### core/cdus_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdus_params.svh"
// Notes on behaviour
// - demand mode: high write loads latch
// - demand mode: low write only stores
// - codes 0-3 wait for timer overflow
// - event copies high:low into latch
// - timers 2/3: split low, else high
// - two channels, independent enable bits
// - four full-scale current settings per channel
// - bias on when any channel enabled
// - merge outputs on one pin if selected
// - codes 4-6: convert-start pin edges
// - left/right justified word mapping
module cdus_top
(
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                clkEn,
	input  wire logic [7:0]          wrData,
	input  wire logic                dac_zero_control_wr,
	input  wire logic                dac_zero_data_high_wr,
	input  wire logic                dac_zero_data_low_wr,
	input  wire logic                dac_one_control_wr,
	input  wire logic                dac_one_data_high_wr,
	input  wire logic                dac_one_data_low_wr,
	input  wire logic                output_merge_select,
	input  wire cdus_pkg::cdus_tmr_s tmrEvt,
	input  wire logic                convert_start_pin,
	output logic [7:0]               dac_zero_control_reg,
	output logic [7:0]               dac_zero_data_high,
	output logic [7:0]               dac_zero_data_low,
	output logic [7:0]               dac_one_control_reg,
	output logic [7:0]               dac_one_data_high,
	output logic [7:0]               dac_one_data_low,
	output logic [11:0]              dacZeroWord,
	output logic [11:0]              dacOneWord,
	output var cdus_pkg::cdus_ctl_s  dacZeroCfg,
	output var cdus_pkg::cdus_ctl_s  dacOneCfg,
	output logic                     biasEnable,
	output logic                     pinZeroConnect,
	output logic                     pinOneConnect,
	output logic                     outputsMerged
);
	logic       pinSync1_ff;
	logic       pinSync2_ff;
	logic       pinPrev_ff;
	logic       pinRise;
	logic       pinFall;
	logic       t2Evt;
	logic       t3Evt;
	logic [7:0] evtVec;

	function automatic cdus_pkg::cdus_ctl_s cfgOf(input logic [7:0] c);
		cfgOf = {c[`CDUS_CTL_EN:`CDUS_CTL_SRC_LO], c[`CDUS_CTL_RJST:`CDUS_CTL_FS_LO]};
	endfunction

	// a split timer counts in bytes, so its low-byte overflow is the event
	function automatic logic pickOvf(input logic split, input logic lowOvf,
		input logic highOvf);
		pickOvf = split ? lowOvf : highOvf;
	endfunction

	// two-flop synchroniser, then edge detect on the second stage
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pinSync1_ff <= 1'b0;
			pinSync2_ff <= 1'b0;
			pinPrev_ff  <= 1'b0;
		end
		else if (clkEn)
		begin
			pinSync1_ff <= convert_start_pin;
			pinSync2_ff <= pinSync1_ff;
			pinPrev_ff  <= pinSync2_ff;
		end
	end

	assign pinRise = pinSync2_ff && !pinPrev_ff;
	assign pinFall = !pinSync2_ff && pinPrev_ff;
	assign t2Evt   = pickOvf(tmrEvt.t2Split, tmrEvt.t2LowOvf, tmrEvt.t2HighOvf);
	assign t3Evt   = pickOvf(tmrEvt.t3Split, tmrEvt.t3LowOvf, tmrEvt.t3HighOvf);
	assign evtVec  = {1'b0, pinRise || pinFall, pinFall, pinRise,
		t3Evt, t2Evt, tmrEvt.t1Ovf, tmrEvt.t0Ovf};

	// both channels share the write data bus and the event vector
	cdus_channel uChZero
	(
		.core_clk    (core_clk),
		.rstn        (rstn),
		.clkEn       (clkEn),
		.ctlWrData   (wrData),
		.ctlWr       (dac_zero_control_wr),
		.wrData      (wrData),
		.highWr      (dac_zero_data_high_wr),
		.lowWr       (dac_zero_data_low_wr),
		.evtVec      (evtVec),
		.ctlReg      (dac_zero_control_reg),
		.dataHighReg (dac_zero_data_high),
		.dataLowReg  (dac_zero_data_low),
		.latchWord   (dacZeroWord)
	);

	cdus_channel uChOne
	(
		.core_clk    (core_clk),
		.rstn        (rstn),
		.clkEn       (clkEn),
		.ctlWrData   (wrData),
		.ctlWr       (dac_one_control_wr),
		.wrData      (wrData),
		.highWr      (dac_one_data_high_wr),
		.lowWr       (dac_one_data_low_wr),
		.evtVec      (evtVec),
		.ctlReg      (dac_one_control_reg),
		.dataHighReg (dac_one_data_high),
		.dataLowReg  (dac_one_data_low),
		.latchWord   (dacOneWord)
	);

	// pin routing follows the enable bits and the merge level
	assign dacZeroCfg = cfgOf(dac_zero_control_reg);
	assign dacOneCfg  = cfgOf(dac_one_control_reg);
	assign biasEnable = dacZeroCfg.enable || dacOneCfg.enable;
	assign outputsMerged  = dacZeroCfg.enable && dacOneCfg.enable && output_merge_select;
	assign pinZeroConnect = dacZeroCfg.enable
		|| (dacOneCfg.enable && output_merge_select);
	assign pinOneConnect  = dacOneCfg.enable && !output_merge_select;

	AST_BIAS: assert property (@(posedge core_clk) disable iff (!rstn)
		biasEnable ==
		(dac_zero_control_reg[`CDUS_CTL_EN] || dac_one_control_reg[`CDUS_CTL_EN]))
		else $error("bias enable mismatch");

	AST_MERGE: assert property (@(posedge core_clk) disable iff (!rstn)
		outputsMerged |->
		(pinZeroConnect && !pinOneConnect))
		else $error("merged outputs on wrong pin");

	AST_MERGE_NEEDS_BOTH: assert property (@(posedge core_clk) disable iff (!rstn)
		(output_merge_select && !(dacZeroCfg.enable && dacOneCfg.enable)) |->
		!outputsMerged)
		else $error("merge shown with a channel disabled");

	AST_PIN_SEPARATE: assert property (@(posedge core_clk) disable iff (!rstn)
		(dacOneCfg.enable && !output_merge_select) |->
		(pinOneConnect && !outputsMerged))
		else $error("channel one not on its own pin");

	AST_PIN_ZERO_ON: assert property (@(posedge core_clk) disable iff (!rstn)
		dacZeroCfg.enable |->
		pinZeroConnect)
		else $error("channel zero pin not connected");

	AST_PIN_IDLE: assert property (@(posedge core_clk) disable iff (!rstn)
		!biasEnable |->
		(!pinZeroConnect && !pinOneConnect))
		else $error("pin connected with both channels off");

	AST_FS_FIELD: assert property (@(posedge core_clk) disable iff (!rstn)
		(dacZeroCfg.fullScale == dac_zero_control_reg[`CDUS_CTL_FS_HI:`CDUS_CTL_FS_LO]) &&
		(dacOneCfg.fullScale == dac_one_control_reg[`CDUS_CTL_FS_HI:`CDUS_CTL_FS_LO]))
		else $error("full-scale field mismatch");

	AST_CH_INDEP_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && dac_zero_control_wr && !dac_one_control_wr) |=>
		$stable(dac_one_control_reg))
		else $error("channel zero write changed channel one");

	AST_CH_INDEP_ONE: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && dac_one_control_wr && !dac_zero_control_wr) |=>
		$stable(dac_zero_control_reg))
		else $error("channel one write changed channel zero");

	AST_FROZEN: assert property (@(posedge core_clk) disable iff (!rstn)
		!clkEn |=>
		$stable({dacZeroWord, dacOneWord, dac_zero_control_reg, dac_one_control_reg}))
		else $error("state moved with clock enable low");

	AST_T2_SPLIT: assert property (@(posedge core_clk) disable iff (!rstn)
		tmrEvt.t2Split |->
		(t2Evt == tmrEvt.t2LowOvf))
		else $error("split timer two used wrong overflow");

	AST_T2_WIDE: assert property (@(posedge core_clk) disable iff (!rstn)
		!tmrEvt.t2Split |->
		(t2Evt == tmrEvt.t2HighOvf))
		else $error("wide timer two used wrong overflow");

	AST_T3_SPLIT: assert property (@(posedge core_clk) disable iff (!rstn)
		tmrEvt.t3Split |->
		(t3Evt == tmrEvt.t3LowOvf))
		else $error("split timer three used wrong overflow");

	AST_T3_WIDE: assert property (@(posedge core_clk) disable iff (!rstn)
		!tmrEvt.t3Split |->
		(t3Evt == tmrEvt.t3HighOvf))
		else $error("wide timer three used wrong overflow");

	AST_EDGE_EXCL: assert property (@(posedge core_clk) disable iff (!rstn)
		!(pinRise &&
		pinFall))
		else $error("rise and fall seen together");

	AST_ANY_EDGE: assert property (@(posedge core_clk) disable iff (!rstn)
		evtVec[`CDUS_SRC_ANY] ==
		(pinRise || pinFall))
		else $error("any-edge event mismatch");

	AST_RISE_DELAY: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && $past(clkEn) && pinRise) |->
		($past(pinSync1_ff) && !pinPrev_ff))
		else $error("rise edge without synchronised pin");

	AST_FALL_DELAY: assert property (@(posedge core_clk) disable iff (!rstn)
		(clkEn && $past(clkEn) && pinFall) |->
		(!$past(pinSync1_ff) && pinPrev_ff))
		else $error("fall edge without synchronised pin");
endmodule
`default_nettype wire

// ### sim/cdus_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cdus_top_tb_top;
	typedef struct packed {logic [7:0] ctl, lo, hi, tmr; logic pin; logic [11:0] word;} cdus_row_s;
	logic                coreClk  = 1'b0;
	logic                rstn     = 1'b0;
	logic                clkEn    = 1'b1;
	logic                mergeSel = 1'b0;
	logic                pinLvl   = 1'b0;
	logic [7:0]          wrData   = 8'h00;
	logic [5:0]          strb     = 6'h00;
	cdus_pkg::cdus_tmr_s tmr      = '0;
	logic [7:0]          ctl0, hi0, lo0, ctl1, hi1, lo1;
	logic [11:0]         word0, word1;
	cdus_pkg::cdus_ctl_s cfg0, cfg1;
	logic                bias, pin0, pin1, merged;
	logic [11:0]         prev     = 12'h000;
	int                  bad_count = 0;
	int                  tests_run = 0;
	// ctl, low, high, timer strobes, pin level, expected word
	cdus_row_s rows [15] = '{
		'{8'hf3, 8'h50, 8'hab, 8'h00, 1'b0, 12'hab5}, '{8'hf7, 8'h34, 8'h12, 8'h00, 1'b0, 12'h234},
		'{8'h83, 8'h10, 8'h22, 8'h80, 1'b0, 12'h221}, '{8'h93, 8'h30, 8'h44, 8'h80, 1'b0, 12'h221},
		'{8'h93, 8'h30, 8'h44, 8'h40, 1'b0, 12'h443}, '{8'ha3, 8'h50, 8'h66, 8'h10, 1'b0, 12'h665},
		'{8'ha3, 8'h70, 8'h88, 8'h28, 1'b0, 12'h887}, '{8'ha3, 8'hd0, 8'had, 8'h18, 1'b0, 12'h887},
		'{8'hb3, 8'h90, 8'haa, 8'h02, 1'b0, 12'haa9}, '{8'hb3, 8'hb0, 8'hcc, 8'h05, 1'b0, 12'hccb},
		'{8'hc3, 8'h10, 8'h20, 8'h00, 1'b1, 12'h201}, '{8'hd3, 8'h20, 8'h30, 8'h00, 1'b0, 12'h302},
		'{8'he3, 8'h30, 8'h40, 8'h00, 1'b1, 12'h403}, '{8'he3, 8'h40, 8'h50, 8'h00, 1'b0, 12'h504},
		'{8'hc3, 8'h60, 8'h70, 8'h00, 1'b0, 12'h504}};
	always #20 coreClk = ~coreClk;
	cdus_top u_cdus_top
	(
		.core_clk              (coreClk),
		.rstn                  (rstn),
		.clkEn                 (clkEn),
		.wrData                (wrData),
		.dac_zero_control_wr   (strb[0]),
		.dac_zero_data_high_wr (strb[1]),
		.dac_zero_data_low_wr  (strb[2]),
		.dac_one_control_wr    (strb[3]),
		.dac_one_data_high_wr  (strb[4]),
		.dac_one_data_low_wr   (strb[5]),
		.output_merge_select   (mergeSel),
		.tmrEvt                (tmr),
		.convert_start_pin     (pinLvl),
		.dac_zero_control_reg  (ctl0),
		.dac_zero_data_high    (hi0),
		.dac_zero_data_low     (lo0),
		.dac_one_control_reg   (ctl1),
		.dac_one_data_high     (hi1),
		.dac_one_data_low      (lo1),
		.dacZeroWord           (word0),
		.dacOneWord            (word1),
		.dacZeroCfg            (cfg0),
		.dacOneCfg             (cfg1),
		.biasEnable            (bias),
		.pinZeroConnect        (pin0),
		.pinOneConnect         (pin1),
		.outputsMerged         (merged)
	);
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input int idx, input logic [7:0] d);
		@(posedge coreClk);
		#1 strb[idx] = 1'b1;
		wrData = d;
		@(posedge coreClk);
		#1 strb = 6'h00;
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#80000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		repeat (8) @(posedge coreClk);
		#1 rstn = 1'b1;
		foreach (rows[i])
		begin
			wr(0, rows[i].ctl);
			wr(2, rows[i].lo);
			wr(1, rows[i].hi);
			chk(ctl0, rows[i].ctl & 8'hf7);
			chk(cfg0, {rows[i].ctl[7:4], rows[i].ctl[2:0]});
			if (rows[i].ctl[6:4] != 3'h7) chk(word0, prev);
			@(posedge coreClk);
			#1 tmr = rows[i].tmr;
			pinLvl = rows[i].pin;
			@(posedge coreClk);
			#1 tmr = '0;
			repeat (4) @(posedge coreClk);
			#1 chk(word0, rows[i].word);
			prev = rows[i].word;
			$display("row %0d done", i);
		end
		mergeSel = 1'b1;
		wr(3, 8'hff);
		chk(ctl1, 8'hf7);
		chk(cfg1, 7'h7f);
		wr(5, 8'h5a);
		chk(word1, 12'h000);
		chk(lo1, 8'h5a);
		wr(4, 8'h03);
		chk(word1, 12'h35a);
		chk(merged, 1'b1);
		chk(pin0, 1'b1);
		chk(pin1, 1'b0);
		wr(0, 8'h73);
		chk(merged, 1'b0);
		chk(bias, 1'b1);
		mergeSel = 1'b0;
		#1 chk(pin1, 1'b1);
		chk(pin0, 1'b0);
		wr(3, 8'h73);
		chk(bias, 1'b0);
		clkEn = 1'b0;
		wr(4, 8'hee);
		chk(hi1, 8'h03);
		clkEn = 1'b1;
		wr(0, 8'hf3);
		wr(2, 8'h00);
		wr(1, 8'h12);
		chk(word0, 12'h120);
		wr(1, 8'h34);
		chk(word0, 12'h340);
		$display("channel one done");
		rstn = 1'b0;
		#5 chk(ctl0, 8'h73);
		chk(ctl1, 8'h73);
		chk(hi0, 8'h00);
		chk(lo0, 8'h00);
		chk(hi1, 8'h00);
		chk(lo1, 8'h00);
		chk(word0, 12'h000);
		chk(word1, 12'h000);
		$display("reset done");
		finish_test();
	end
endmodule
`default_nettype wire
